// [shared/tass_defines.svh]
/*
 * Offsets, field positions, reset values and codes for the timer trigger
 * and source select block.
 * Assumes inclusion by bare name from any file that needs them.
 */
`ifndef TASS_DEFINES_SVH
`define TASS_DEFINES_SVH

`define TASS_ADDR_W           16
`define TASS_DATA_W           8
`define TASS_UNITS            5
// register offsets
`define TASS_OFS_ONESHOT      16'h0322
`define TASS_OFS_TRIGGER      16'h0343
`define TASS_OFS_SRC4         16'h0350
// reset values
`define TASS_RST_ONESHOT      8'h00
`define TASS_RST_TRIGGER      8'h00
`define TASS_RST_SRC4         8'h00
// field positions
`define TASS_ZIE_BIT          5
`define TASS_U0TRG_LSB        6
`define TASS_OPT_BIT          3
`define TASS_SRC_LSB          0
`define TASS_SRC_MSB          2
`define TASS_SRC4_USED        8'h0F
// unit mode code for one-shot operation
`define TASS_MODE_ONESHOT     2'h2
// source tick indices
`define TASS_TICK_W           7
`define TASS_TICK_ALT         6

`endif

// [shared/tass_pkg.sv]
/*
 * Types for the timer trigger and source select block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tass_pkg;

   typedef logic [7:0] tass_byte_t;

   typedef enum logic [1:0] {
      TASS_TRG_PIN  = 2'h0,
      TASS_TRG_TB2  = 2'h1,
      TASS_TRG_PREV = 2'h2,
      TASS_TRG_NEXT = 2'h3
   } tass_trig_e;

   typedef enum logic [2:0] {
      TASS_SRC_DIV1_2 = 3'h0,
      TASS_SRC_DIV8   = 3'h1,
      TASS_SRC_DIV32  = 3'h2,
      TASS_SRC_DIV64  = 3'h3,
      TASS_SRC_BAD4   = 3'h4,
      TASS_SRC_SLOW   = 3'h5,
      TASS_SRC_SUB32K = 3'h6,
      TASS_SRC_BAD7   = 3'h7
   } tass_src_e;

endpackage

// [rtl/tass_top.sv]
/*
 * Trigger source select, one-shot start, Z-phase enable and fifth-unit
 * count source select for a group of five general-purpose timers.
 * Assumes the counters, mode registers and tick generators sit outside
 * on REF_CLK; event pins and the Z-phase pin are asynchronous.
 */
// Design decision made here: the plain strobed port.
// Summary of operation
// - writing 1 to a one-shot bit starts that unit in one-shot mode when its UNIT_START_SEL bit is 0.
// - the five one-shot start bits always read back as zero.
// - Z-phase enable bit 0 blocks the Z-phase input, 1 passes it.
// - unit0 trigger b7:b6 picks own pin, timer2, unit4 or unit1.
// - unit1 trigger b1:b0 picks own pin, timer2, unit0 or unit2.
// - unit2 trigger b3:b2 picks own pin, timer2, unit1 or unit3.
// - unit3 trigger b5:b4 picks own pin, timer2, unit2 or unit4.
// - unit4 trigger b7:b6 picks own pin, timer2, unit3 or unit0.
// - a selected timer delivers its overflow or underflow event.
// - fifth-unit source field picks divided clocks, slow osc or 32k.
// - option bit 1 uses the alternative select, 0 the 3-bit field.
`timescale 1ns/1ps
`default_nettype none
`include "tass_defines.svh"

module tass_top
   import tass_pkg::*;
(
   input  wire logic                        REF_CLK,
   input  wire logic                        RST_N,
   input  wire logic [`TASS_ADDR_W-1:0]     ADDR,
   input  wire logic [`TASS_DATA_W-1:0]     WR_DATA,
   input  wire logic                        WR_STB,
   input  wire logic                        RD_STB,
   output logic      [`TASS_DATA_W-1:0]     RD_DATA,
   input  wire logic [2*`TASS_UNITS-1:0]    UNIT_MODE,
   input  wire logic [`TASS_UNITS-1:0]      UNIT_START_SEL,
   input  wire logic [`TASS_UNITS-1:0]      UNIT_EVENT_PIN,
   input  wire logic [`TASS_UNITS-1:0]      UNIT_OVF,
   input  wire logic                        TB2_OVF,
   input  wire logic                        ZPHASE_PIN,
   input  wire logic [`TASS_TICK_W-1:0]     SRC_TICK,
   output logic      [`TASS_UNITS-1:0]      ONESHOT_START,
   output logic      [`TASS_UNITS-1:0]      UNIT_TRIGGER,
   output logic                             ZPHASE_EN,
   output logic                             ZPHASE_EVENT,
   output logic                             UNIT4_COUNT_TICK
);

   localparam int N = `TASS_UNITS;

   ////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic trig_pick(input logic [1:0] sel,
                                      input logic       pin,
                                      input logic       tb2,
                                      input logic       prev_ovf,
                                      input logic       next_ovf);
      logic res;
      res = 1'b0;
      unique case (tass_trig_e'(sel))
         TASS_TRG_PIN:  res = pin;
         TASS_TRG_TB2:  res = tb2;
         TASS_TRG_PREV: res = prev_ovf;
         TASS_TRG_NEXT: res = next_ovf;
      endcase
      return res;
   endfunction

   function automatic logic hit(input logic [`TASS_ADDR_W-1:0] a,
                                input logic [`TASS_ADDR_W-1:0] ofs);
      return a == ofs;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // registers

   tass_byte_t oneshot_reg;
   tass_byte_t trigger_reg;
   tass_byte_t src4_reg;
   logic       wr_oneshot;
   logic       wr_trigger;
   logic       wr_src4;

   assign wr_oneshot = WR_STB && hit(ADDR, `TASS_OFS_ONESHOT);
   assign wr_trigger = WR_STB && hit(ADDR, `TASS_OFS_TRIGGER);
   assign wr_src4    = WR_STB && hit(ADDR, `TASS_OFS_SRC4);

   // start bits are never stored, only their write pulse is used
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         oneshot_reg <= `TASS_RST_ONESHOT;
      end else if (wr_oneshot) begin
         oneshot_reg <= {WR_DATA[7:`TASS_ZIE_BIT], 5'h00};
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         trigger_reg <= `TASS_RST_TRIGGER;
      end else if (wr_trigger) begin
         trigger_reg <= WR_DATA;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         src4_reg <= `TASS_RST_SRC4;
      end else if (wr_src4) begin
         src4_reg <= WR_DATA & `TASS_SRC4_USED;
      end
   end

   tass_byte_t rd_data_next;

   always_comb begin
      rd_data_next = 8'h00;
      if (RD_STB) begin
         if (hit(ADDR, `TASS_OFS_ONESHOT)) begin
            rd_data_next = oneshot_reg & 8'hE0;
         end else if (hit(ADDR, `TASS_OFS_TRIGGER)) begin
            rd_data_next = trigger_reg;
         end else if (hit(ADDR, `TASS_OFS_SRC4)) begin
            rd_data_next = src4_reg;
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         RD_DATA <= 8'h00;
      end else begin
         RD_DATA <= rd_data_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // one-shot start

   logic [N-1:0] start_next;

   always_comb begin
      start_next = '0;
      for (int i = 0; i < N; i++) begin
         start_next[i] = wr_oneshot && WR_DATA[i]
                      && UNIT_MODE[2*i +: 2] == `TASS_MODE_ONESHOT
                      && !UNIT_START_SEL[i];
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         ONESHOT_START <= '0;
      end else begin
         ONESHOT_START <= start_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers: a level is taken once stages two and three agree

   logic [N:0] pin_s1_reg;
   logic [N:0] pin_s2_reg;
   logic [N:0] pin_s3_reg;
   logic [N:0] pin_reg;

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         pin_s1_reg <= '0;
         pin_s2_reg <= '0;
         pin_s3_reg <= '0;
      end else begin
         pin_s1_reg <= {ZPHASE_PIN, UNIT_EVENT_PIN};
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         pin_reg <= '0;
      end else begin
         for (int i = 0; i <= N; i++) begin
            if (pin_s2_reg[i] == pin_s3_reg[i]) begin
               pin_reg[i] <= pin_s3_reg[i];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // trigger selection

   logic [1:0]   trg_sel [N];
   logic [N-1:0] trigger_next;

   assign trg_sel[0] = oneshot_reg[`TASS_U0TRG_LSB +: 2];
   assign trg_sel[1] = trigger_reg[1:0];
   assign trg_sel[2] = trigger_reg[3:2];
   assign trg_sel[3] = trigger_reg[5:4];
   assign trg_sel[4] = trigger_reg[7:6];

   // neighbours wrap round the ring of five; pins rely on software
   // having set the port as input
   always_comb begin
      trigger_next = '0;
      for (int i = 0; i < N; i++) begin
         trigger_next[i] = trig_pick(trg_sel[i], pin_reg[i], TB2_OVF,
                                     UNIT_OVF[(i + N - 1) % N],
                                     UNIT_OVF[(i + 1) % N]);
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         UNIT_TRIGGER <= '0;
      end else begin
         UNIT_TRIGGER <= trigger_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Z-phase gate

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         ZPHASE_EN    <= 1'b0;
         ZPHASE_EVENT <= 1'b0;
      end else begin
         ZPHASE_EN    <= oneshot_reg[`TASS_ZIE_BIT];
         ZPHASE_EVENT <= oneshot_reg[`TASS_ZIE_BIT] && pin_reg[N];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // fifth-unit count source

   logic tick_next;

   // forbidden codes give no tick rather than an arbitrary source
   always_comb begin
      tick_next = 1'b0;
      if (src4_reg[`TASS_OPT_BIT]) begin
         tick_next = SRC_TICK[`TASS_TICK_ALT];
      end else begin
         unique case (tass_src_e'(src4_reg[`TASS_SRC_MSB:`TASS_SRC_LSB]))
            TASS_SRC_DIV1_2: tick_next = SRC_TICK[0];
            TASS_SRC_DIV8:   tick_next = SRC_TICK[1];
            TASS_SRC_DIV32:  tick_next = SRC_TICK[2];
            TASS_SRC_DIV64:  tick_next = SRC_TICK[3];
            TASS_SRC_SLOW:   tick_next = SRC_TICK[4];
            TASS_SRC_SUB32K: tick_next = SRC_TICK[5];
            TASS_SRC_BAD4:   tick_next = 1'b0;
            TASS_SRC_BAD7:   tick_next = 1'b0;
         endcase
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         UNIT4_COUNT_TICK <= 1'b0;
      end else begin
         UNIT4_COUNT_TICK <= tick_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);

   sequence os_write_ok(int i);
      wr_oneshot && WR_DATA[i] && !UNIT_START_SEL[i]
         && UNIT_MODE[2*i +: 2] == `TASS_MODE_ONESHOT;
   endsequence

   oneshot_fire_a: assert property (
      os_write_ok(0) |=> ONESHOT_START[0])
      else $error("one-shot start missing");

   oneshot_block_a: assert property (
      (wr_oneshot && WR_DATA[2] && UNIT_START_SEL[2]) |=> !ONESHOT_START[2])
      else $error("gated one-shot start fired");

   oneshot_read_a: assert property (
      (RD_STB && hit(ADDR, `TASS_OFS_ONESHOT)) |=> RD_DATA[4:0] == 5'h00)
      else $error("one-shot bits read nonzero");

   sequence zie_set;
      wr_oneshot && WR_DATA[`TASS_ZIE_BIT] ##1 1'b1;
   endsequence

   zphase_gate_a: assert property (
      !ZPHASE_EN |-> !ZPHASE_EVENT)
      else $error("Z-phase passed while disabled");

   zphase_enable_a: assert property (
      zie_set |=> ZPHASE_EN)
      else $error("Z-phase enable not applied");

   unit0_prev_a: assert property (
      (trg_sel[0] == 2'h2 && UNIT_OVF[4]) |=> UNIT_TRIGGER[0])
      else $error("unit0 missed unit4 overflow");

   unit1_tb2_a: assert property (
      (trg_sel[1] == 2'h1) |=> UNIT_TRIGGER[1] == $past(TB2_OVF))
      else $error("unit1 not following timer2");

   unit2_next_a: assert property (
      (trg_sel[2] == 2'h3) |=> UNIT_TRIGGER[2] == $past(UNIT_OVF[3]))
      else $error("unit2 not following unit3");

   unit3_pin_a: assert property (
      (trg_sel[3] == 2'h0) |=> UNIT_TRIGGER[3] == $past(pin_reg[3]))
      else $error("unit3 not following its pin");

   unit4_wrap_a: assert property (
      (trg_sel[4] == 2'h3) |=> UNIT_TRIGGER[4] == $past(UNIT_OVF[0]))
      else $error("unit4 not following unit0");

   src_alt_a: assert property (
      src4_reg[`TASS_OPT_BIT]
         |=> UNIT4_COUNT_TICK == $past(SRC_TICK[`TASS_TICK_ALT]))
      else $error("option bit ignored");

   src_div8_a: assert property (
      (src4_reg[3:0] == 4'h1) |=> UNIT4_COUNT_TICK == $past(SRC_TICK[1]))
      else $error("divide-by-8 source not used");

endmodule // tass_top

`default_nettype wire

// [testbench/tass_far_model.sv]
/*
 Far side of the trigger select block: event pins, timer overflow
 pulses, Z-phase pin and count ticks.
 Assumes the bench moves requests just after rising edges.
*/
`timescale 1ns/1ps
`default_nettype none
module tass_far_model (
   input  wire logic [4:0] ovf_req,
   input  wire logic       tb2_req,
   input  wire logic [4:0] pin_req,
   input  wire logic       zpin_req,
   input  wire logic [6:0] tick_req,
   output logic      [4:0] unit_ovf,
   output logic            tb2_ovf,
   output logic      [4:0] event_pin,
   output logic            zphase_pin,
   output logic      [6:0] src_tick
);
////////////////////////////////////////
   // pins are only ever driven into the block, as inputs
   assign event_pin  = pin_req;
   assign zphase_pin = zpin_req;
   // no two-phase stimulus, its enables stay cleared
   assign unit_ovf   = ovf_req;
   assign tb2_ovf    = tb2_req;
   assign src_tick   = tick_req;
endmodule // tass_far_model
`default_nettype wire

// [testbench/tass_bench.sv]
/*
 Self-checking bench for the trigger and source select block.
 Assumes tass_pkg, tass_top and tass_far_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tass_defines.svh"
module timer_a_trigger_source_select_bench import tass_pkg::*;;
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic [15:0] addr = 16'h0000;
   tass_byte_t wdata = 8'h00;
   tass_byte_t rdata;
   logic       wstb = 1'b0;
   logic       rstb = 1'b0;
   logic [9:0] mode = 10'h000;
   logic [4:0] ssel = 5'h00;
   logic [4:0] ovf_q = 5'h00;
   logic [4:0] pin_q = 5'h00;
   logic       tb2_q = 1'b0;
   logic       zpin_q = 1'b0;
   logic [6:0] tick_q = 7'h00;
   logic [4:0] ovf, pin, start, trig, exp;
   logic       tb2, zpin, zen, zev, tick4;
   logic [6:0] tick;
   int         mismatches = 0;
   int         cmp_count = 0;

   always #2 clk = ~clk;

   tass_top i_dut (.REF_CLK(clk), .RST_N(rst_n), .ADDR(addr),
      .WR_DATA(wdata), .WR_STB(wstb), .RD_STB(rstb), .RD_DATA(rdata),
      .UNIT_MODE(mode), .UNIT_START_SEL(ssel), .UNIT_EVENT_PIN(pin),
      .UNIT_OVF(ovf), .TB2_OVF(tb2), .ZPHASE_PIN(zpin),
      .SRC_TICK(tick), .ONESHOT_START(start), .UNIT_TRIGGER(trig),
      .ZPHASE_EN(zen), .ZPHASE_EVENT(zev), .UNIT4_COUNT_TICK(tick4));
   tass_far_model i_far (.ovf_req(ovf_q), .tb2_req(tb2_q),
      .pin_req(pin_q), .zpin_req(zpin_q), .tick_req(tick_q),
      .unit_ovf(ovf), .tb2_ovf(tb2), .event_pin(pin),
      .zphase_pin(zpin), .src_tick(tick));
////////////////////////////////////////
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input tass_byte_t s, input tass_byte_t e);
      cmp_count++;
      if (s !== e) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask

   task automatic wr(input logic [15:0] a, input tass_byte_t d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wstb <= 1'b1;
      @(posedge clk);
      wstb <= 1'b0;
      #1;
   endtask

   task automatic rdchk(input logic [15:0] a, input tass_byte_t e);
      @(posedge clk);
      addr <= a;
      rstb <= 1'b1;
      @(posedge clk);
      rstb <= 1'b0;
      #1;
      chk(rdata, e);
   endtask

   // one-cycle source pulse, outputs settled after the sampling edge
   task automatic pulse(input logic [4:0] o, input logic t,
                        input logic [6:0] k);
      @(posedge clk);
      ovf_q <= o;
      tb2_q <= t;
      tick_q <= k;
      @(posedge clk);
      ovf_q <= 5'h00;
      tb2_q <= 1'b0;
      tick_q <= 7'h00;
      #1;
   endtask

   // forbidden codes select nothing
   function automatic int src_idx(input int s);
      if (s == 8) return 6;
      if (s < 4) return s;
      if (s == 5 || s == 6) return s - 1;
      return -1;
   endfunction
////////////////////////////////////////
   initial begin
      #100000;
      mismatches++;
      end_of_test();
   end

   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rdchk(`TASS_OFS_ONESHOT, `TASS_RST_ONESHOT);
      @(posedge clk);
      #1;
      chk(rdata, 8'h00);
      rdchk(`TASS_OFS_TRIGGER, `TASS_RST_TRIGGER);
      rdchk(`TASS_OFS_SRC4, `TASS_RST_SRC4);
      wr(16'h0323, 8'hFF);
      rdchk(16'h0323, 8'h00);
      wr(`TASS_OFS_TRIGGER, 8'hE4);
      rdchk(`TASS_OFS_TRIGGER, 8'hE4);
      wr(`TASS_OFS_SRC4, 8'hFF);
      rdchk(`TASS_OFS_SRC4, 8'h0F);
      @(posedge clk);
      mode <= 10'h2AA;
      wr(`TASS_OFS_ONESHOT, 8'h1F);
      chk({3'h0, start}, 8'h1F);
      @(posedge clk);
      #1;
      chk({3'h0, start}, 8'h00);
      rdchk(`TASS_OFS_ONESHOT, 8'h00);
      @(posedge clk);
      mode <= 10'h26A;
      ssel <= 5'h04;
      wr(`TASS_OFS_ONESHOT, 8'h1F);
      chk({3'h0, start}, 8'h13);
      wr(`TASS_OFS_ONESHOT, 8'h20);
      @(posedge clk);
      zpin_q <= 1'b1;
      #1;
      chk({7'h0, zen}, 8'h01);
      repeat (8) @(posedge clk);
      #1;
      chk({7'h0, zev}, 8'h01);
      wr(`TASS_OFS_ONESHOT, 8'h00);
      repeat (2) @(posedge clk);
      #1;
      chk({6'h0, zen, zev}, 8'h00);
      @(posedge clk);
      pin_q <= 5'h15;
      wr(`TASS_OFS_TRIGGER, 8'h00);
      repeat (8) @(posedge clk);
      #1;
      chk({3'h0, trig}, 8'h15);
      for (int c = 1; c < 4; c++) begin
         wr(`TASS_OFS_ONESHOT, {c[1:0], 6'h00});
         wr(`TASS_OFS_TRIGGER, {4{c[1:0]}});
         for (int k = 0; k < 5; k++) begin
            exp = (c == 1) ? 5'h1F : (c == 2) ? 5'(1 << ((k + 1) % 5))
                                              : 5'(1 << ((k + 4) % 5));
            pulse(5'(1 << k), c == 1, 7'h00);
            chk({3'h0, trig}, {3'h0, exp});
         end
      end
      for (int s = 0; s < 9; s++) begin
         wr(`TASS_OFS_SRC4, (s == 8) ? 8'h0B : 8'(s));
         for (int j = 0; j < 7; j++) begin
            pulse(5'h00, 1'b0, 7'(1 << j));
            chk({7'h0, tick4}, 8'(j == src_idx(s)));
         end
      end
      end_of_test();
   end
endmodule // timer_a_trigger_source_select_bench
`default_nettype wire
